//--- rtl/pmas_params.svh
// offsets, field positions, reset values and timing counts for the status bank
`ifndef PMAS_PARAMS_SVH
`define PMAS_PARAMS_SVH
`define PMAS_IDX_PORT       1'b0
`define PMAS_DATA_PORT      1'b1
`define PMAS_OFF_SMI_STATUS_ONE  8'h74
`define PMAS_OFF_PINACT     8'h75
`define PMAS_OFF_ACT0       8'h77
`define PMAS_OFF_ACT1       8'h78
`define PMAS_RESET_VAL      8'h00
`define PMAS_SOFT_BIT       7
`define PMAS_CTRL_SOFT_BIT  1
`define PMAS_PINACT_MASK    8'hfc
`define PMAS_ACT0_MASK      8'hfe
`define PMAS_ACT1_MASK      8'h20
`define PMAS_SOFT_MASK      8'h80
`define PMAS_RELEASE_NS     60
`define PMAS_CLK_NS         20
`define PMAS_RELEASE_CYC    (`PMAS_RELEASE_NS / `PMAS_CLK_NS)
`endif

//--- rtl/pmas_pkg.sv
// types shared by the status bank
package pmas_pkg;
  typedef struct packed {
    logic parallel_port_act;
    logic serial_port_act;
    logic keyboard_act;
    logic floppy_ctrl_act;
    logic disk_ctrl_act;
    logic addr_range0_act;
    logic dma_req_act;
    logic pci_master_act;
  } pmas_src_t;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       port;
    logic [7:0] data;
  } pmas_io_t;
endpackage

//--- rtl/pmas_irq_gate.sv
// management interrupt gating of status bits with their enables
`timescale 1ns/1ns
`include "pmas_params.svh"
module pmas_irq_gate
  import pmas_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic [7:0] soft_in,
  input  wire logic [7:0] pinact_in,
  input  wire logic [7:0] pinact_en_in,
  input  wire logic       soft_en_in,
  output logic            mgmt_irq_n_out
);
  logic cause;
  // one register stage keeps release well inside the allowed window
  assign cause = (soft_en_in & |(soft_in & `PMAS_SOFT_MASK))
               | |(pinact_in & pinact_en_in & `PMAS_PINACT_MASK);
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mgmt_irq_n_out <= 1'b1;
    end else begin
      mgmt_irq_n_out <= ~cause;
    end
  end
endmodule

//--- rtl/pmas_status_bank.sv
// indexed status registers for management interrupt and activity sources
`timescale 1ns/1ns
`include "pmas_params.svh"
// Notes on behaviour
// - control bit 1 write sets soft flag
// - timer sets inactivity bit, activity clears it
// - writing one clears a set inactivity bit
// - status updates ungated; interrupt needs enable
// - inactivity bits: par,ser,kbd,fdd,hdd,ar0 7..2
// - activity sticky until w1c, reset, auto-doze
// - activity recorded regardless of enables
// - activity0 bits: dma,pci,par,ser,kbd,fdd,hdd
// - activity1 bit5 address range 0
// - all status registers reset to zero
// - output is gated OR, released quickly
module pmas_status_bank
  import pmas_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire pmas_io_t   io_in,
  input  wire logic       soft_req_in,
  input  wire pmas_src_t  act_in,
  input  wire logic [5:0] periph_timeout_in,
  input  wire logic [7:0] pinact_en_in,
  input  wire logic       soft_en_in,
  input  wire logic       auto_pm_in,
  input  wire logic       doze_entry_in,
  output logic [7:0]      rd_data_out,
  output logic            mgmt_irq_n_out
);
  logic [7:0] index;
  logic [7:0] smi_status_one;
  logic [7:0] peripheral_inactivity_status;
  logic [7:0] activity_status_zero;
  logic [7:0] activity_status_one;
  logic [7:0] act0_vec;
  logic [7:0] act1_vec;
  logic [7:0] pin_act_vec;
  logic [7:0] pin_set_vec;
  logic [7:0] wr_mask0;
  logic [7:0] wr_mask1;
  logic [7:0] wr_mask_p;
  logic [7:0] wr_mask_s;
  logic       data_wr;

  // everything the mask depends on is an argument, so the assigns re-evaluate
  function automatic logic [7:0] w1c_mask(input logic       wr,
                                          input logic [7:0] idx,
                                          input logic [7:0] wdata,
                                          input logic [7:0] off);
    w1c_mask = (wr && idx == off) ? wdata : 8'h00;
  endfunction

  assign data_wr = io_in.wr & (io_in.port == `PMAS_DATA_PORT);
  assign act0_vec = {act_in.dma_req_act, act_in.pci_master_act,
                     act_in.parallel_port_act, act_in.serial_port_act,
                     act_in.keyboard_act, act_in.floppy_ctrl_act,
                     act_in.disk_ctrl_act, 1'b0};
  assign act1_vec = {2'b00, act_in.addr_range0_act, 5'b00000};
  assign pin_act_vec = {act_in.parallel_port_act, act_in.serial_port_act,
                        act_in.keyboard_act, act_in.floppy_ctrl_act,
                        act_in.disk_ctrl_act, act_in.addr_range0_act,
                        2'b00};
  assign pin_set_vec = {periph_timeout_in, 2'b00};
  assign wr_mask0  = w1c_mask(data_wr, index, io_in.data, `PMAS_OFF_ACT0);
  assign wr_mask1  = w1c_mask(data_wr, index, io_in.data, `PMAS_OFF_ACT1);
  assign wr_mask_p = w1c_mask(data_wr, index, io_in.data, `PMAS_OFF_PINACT);
  assign wr_mask_s = w1c_mask(data_wr, index, io_in.data,
                              `PMAS_OFF_SMI_STATUS_ONE);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      index <= 8'h00;
    end else if (io_in.wr && io_in.port == `PMAS_IDX_PORT) begin
      index <= io_in.data;
    end
  end

  // the set from the control write wins over a clear in the same cycle
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      smi_status_one <= `PMAS_RESET_VAL;
    end else if (soft_req_in) begin
      smi_status_one <= `PMAS_SOFT_MASK;
    end else begin
      smi_status_one <= smi_status_one & ~wr_mask_s;
    end
  end

  // activity clearing outranks a timeout that lands in the same cycle
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      peripheral_inactivity_status <= `PMAS_RESET_VAL;
    end else begin
      peripheral_inactivity_status <=
        ((peripheral_inactivity_status & ~wr_mask_p) | pin_set_vec)
        & ~pin_act_vec & `PMAS_PINACT_MASK;
    end
  end

  // doze or standby entry clears only when auto management is on
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      activity_status_zero <= `PMAS_RESET_VAL;
      activity_status_one  <= `PMAS_RESET_VAL;
    end else if (auto_pm_in && doze_entry_in) begin
      activity_status_zero <= act0_vec;
      activity_status_one  <= act1_vec;
    end else begin
      activity_status_zero <= ((activity_status_zero & ~wr_mask0) | act0_vec)
                              & `PMAS_ACT0_MASK;
      activity_status_one  <= ((activity_status_one & ~wr_mask1) | act1_vec)
                              & `PMAS_ACT1_MASK;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_data_out <= 8'h00;
    end else if (io_in.port == `PMAS_IDX_PORT) begin
      rd_data_out <= index;
    end else begin
      case (index)
        `PMAS_OFF_SMI_STATUS_ONE: rd_data_out <= smi_status_one;
        `PMAS_OFF_PINACT:    rd_data_out <= peripheral_inactivity_status;
        `PMAS_OFF_ACT0:      rd_data_out <= activity_status_zero;
        `PMAS_OFF_ACT1:      rd_data_out <= activity_status_one;
        default:             rd_data_out <= 8'h00;
      endcase
    end
  end

  pmas_irq_gate u_gate (
    .clk_in         (clk_in),
    .rst_in         (rst_in),
    .soft_in        (smi_status_one),
    .pinact_in      (peripheral_inactivity_status),
    .pinact_en_in   (pinact_en_in),
    .soft_en_in     (soft_en_in),
    .mgmt_irq_n_out (mgmt_irq_n_out)
  );
endmodule

//--- testbench/pmas_status_bank_properties.sv
// port-level checks for the status bank
`timescale 1ns/1ns
module pmas_status_props
  import pmas_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire pmas_io_t   io_in,
  input  wire logic       soft_req_in,
  input  wire pmas_src_t  act_in,
  input  wire logic [5:0] periph_timeout_in,
  input  wire logic [7:0] pinact_en_in,
  input  wire logic       soft_en_in,
  input  wire logic [7:0] rd_data_out,
  input  wire logic       mgmt_irq_n_out
);
  logic [7:0] idx;
  // mirror of the index, so data reads can be tied to their register
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in) idx <= 8'h00;
    else if (io_in.wr && !io_in.port) idx <= io_in.data;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  rst_idle_a: assert property ($fell(rst_in) |-> mgmt_irq_n_out)
    else $error("interrupt active after reset");
  soft_irq_a: assert property (soft_req_in && soft_en_in
    |-> ##[1:3] !mgmt_irq_n_out) else $error("soft flag gave no interrupt");
  gated_off_a: assert property ((!soft_en_in && pinact_en_in == 8'h00)[*3]
    |-> mgmt_irq_n_out) else $error("interrupt with all enables off");
  pinact_irq_a: assert property (periph_timeout_in[5] && pinact_en_in[7] &&
    !act_in.parallel_port_act |-> ##[1:3] !mgmt_irq_n_out)
    else $error("enabled inactivity gave no interrupt");
  idx_read_a: assert property (io_in.rd && !io_in.port
    |=> rd_data_out == $past(idx)) else $error("index readback wrong");
  unmapped_a: assert property (io_in.rd && io_in.port && idx == 8'h76
    |=> rd_data_out == 8'h00) else $error("unmapped index not zero");
  pinact_rsv_a: assert property (io_in.rd && io_in.port && idx == 8'h75
    |=> rd_data_out[1:0] == 2'b00) else $error("inactivity spare bits set");
  act1_rsv_a: assert property (io_in.rd && io_in.port && idx == 8'h78
    |=> (rd_data_out & 8'hdf) == 8'h00) else $error("activity 1 spare bits set");
endmodule

//--- testbench/test_pmas_status_bank.sv
// self-checking bench for the status bank
`timescale 1ns/1ns
module test_pmas_status_bank
  import pmas_pkg::*;
;
  logic       clk_in = 1'b0;
  logic       rst_in = 1'b1;
  pmas_io_t   io_in = '0;
  logic       soft_req_in = 1'b0;
  pmas_src_t  act_in = '0;
  logic [5:0] periph_timeout_in = 6'h00;
  logic [7:0] pinact_en_in = 8'h00;
  logic       soft_en_in = 1'b0;
  logic       auto_pm_in = 1'b0;
  logic       doze_entry_in = 1'b0;
  logic [7:0] rd_data_out;
  logic       mgmt_irq_n_out;
  int         errors = 0;
  int         check_count = 0;
  logic [7:0] offs [5] = '{8'h74, 8'h75, 8'h77, 8'h78, 8'h76};
  logic [7:0] a0 [8] = '{8'h20, 8'h10, 8'h08, 8'h04,
                         8'h02, 8'h00, 8'h80, 8'h40};
  always #10 clk_in = ~clk_in;
  pmas_status_bank dut (.clk_in, .rst_in, .io_in, .soft_req_in, .act_in,
    .periph_timeout_in, .pinact_en_in, .soft_en_in, .auto_pm_in,
    .doze_entry_in, .rd_data_out, .mgmt_irq_n_out);
  task automatic wrap_up();
    if (errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // strobes drop after one edge but the port is kept, so the read stays put
  task automatic put(input logic w, input logic p, input logic [7:0] d);
    io_in <= '{w, !w, p, d};
    @(posedge clk_in);
    io_in.wr <= 1'b0;
    io_in.rd <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic acc(input logic w, input logic [7:0] i, d, exp);
    put(1'b1, 1'b0, i);
    put(w, 1'b1, d);
    if (!w) check(rd_data_out, exp);
  endtask
  initial begin
    #100000;
    errors++;
    wrap_up();
  end
  initial begin
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    foreach (offs[i]) acc(1'b0, offs[i], 8'h00, 8'h00);
    put(1'b0, 1'b0, 8'h00);
    check(rd_data_out, 8'h76);
    soft_en_in <= 1'b1;
    soft_req_in <= 1'b1;
    @(posedge clk_in);
    soft_req_in <= 1'b0;
    acc(1'b0, 8'h74, 8'h00, 8'h80);
    check({7'h00, mgmt_irq_n_out}, 8'h00);
    acc(1'b1, 8'h74, 8'h80, 8'h00);
    acc(1'b0, 8'h74, 8'h00, 8'h00);
    check({7'h00, mgmt_irq_n_out}, 8'h01);
    soft_en_in <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      act_in <= pmas_src_t'(8'h80 >> i);
      @(posedge clk_in);
      act_in <= '0;
      acc(1'b0, 8'h77, 8'h00, a0[i]);
      acc(1'b0, 8'h78, 8'h00, (i == 5) ? 8'h20 : 8'h00);
      acc(1'b1, 8'h77, 8'hfe, 8'h00);
      acc(1'b1, 8'h78, 8'h20, 8'h00);
    end
    pinact_en_in <= 8'h80;
    periph_timeout_in <= 6'h3f;
    @(posedge clk_in);
    periph_timeout_in <= 6'h00;
    acc(1'b0, 8'h75, 8'h00, 8'hfc);
    check({7'h00, mgmt_irq_n_out}, 8'h00);
    act_in <= pmas_src_t'(8'h80);
    @(posedge clk_in);
    act_in <= '0;
    acc(1'b0, 8'h75, 8'h00, 8'h7c);
    check({7'h00, mgmt_irq_n_out}, 8'h01);
    acc(1'b1, 8'h75, 8'h40, 8'h00);
    acc(1'b0, 8'h75, 8'h00, 8'h3c);
    auto_pm_in <= 1'b1;
    doze_entry_in <= 1'b1;
    @(posedge clk_in);
    doze_entry_in <= 1'b0;
    acc(1'b0, 8'h77, 8'h00, 8'h00);
    periph_timeout_in <= 6'h3f;
    @(posedge clk_in);
    periph_timeout_in <= 6'h00;
    repeat (2) @(posedge clk_in);
    check({7'h00, mgmt_irq_n_out}, 8'h00);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    acc(1'b0, 8'h75, 8'h00, 8'h00);
    check({7'h00, mgmt_irq_n_out}, 8'h01);
    wrap_up();
  end
endmodule
bind pmas_status_bank pmas_status_props chk (.clk_in, .rst_in, .io_in,
  .soft_req_in, .act_in, .periph_timeout_in, .pinact_en_in, .soft_en_in,
  .rd_data_out, .mgmt_irq_n_out);
